// *** hdl/iicb_map.vh ***
`ifndef IICB_MAP_VH
`define IICB_MAP_VH
// Register byte addresses
`define IICB_ADDR_RX_UNDERFLOW_CLEAR_FIELD 32'h50001344
`define IICB_ADDR_RX_OVERFLOW_CLEAR_FIELD  32'h50001348
`define IICB_ADDR_TX_OVERFLOW_CLEAR_FIELD  32'h5000134c
`define IICB_ADDR_READ_REQUEST_CLEAR_FIELD   32'h50001350
`define IICB_ADDR_CLR_TX_ABORT 32'h50001354
`define IICB_ADDR_RX_DONE_CLEAR_FIELD  32'h50001358
`define IICB_ADDR_BUS_ACTIVITY_CLEAR_FIELD 32'h5000135c
`define IICB_ADDR_CLR_STOP     32'h50001360
`define IICB_ADDR_CLR_START    32'h50001364
`define IICB_ADDR_GENERAL_CALL_CLEAR_FIELD 32'h50001368
`define IICB_ADDR_ENABLE       32'h5000136c
`define IICB_ADDR_RAW_STATUS   32'h50001390
`define IICB_ADDR_IRQ_MASK     32'h50001394
`define IICB_ADDR_ABORT_SRC    32'h50001398
// Raw interrupt status bit positions
`define IICB_BIT_RX_UNDER 0
`define IICB_BIT_RX_OVER  1
`define IICB_BIT_TX_OVER  3
`define IICB_BIT_RD_REQ   5
`define IICB_BIT_TX_ABORT 6
`define IICB_BIT_RX_DONE  7
`define IICB_BIT_ACTIVITY 8
`define IICB_BIT_STOP     9
`define IICB_BIT_START    10
`define IICB_BIT_GENERAL_CALL_IRQ 11
// Abort source bit kept across a clear when restarts are off
`define IICB_BIT_ABORT_KEEP 9
// Widths and reset values
`define IICB_RAW_W        12
`define IICB_ABORT_W      16
`define IICB_RAW_RESET    12'h000
`define IICB_MASK_RESET   12'h000
`define IICB_ABORT_RESET  16'h0000
`define IICB_ENABLE_RESET 1'h0
// Bits that this bank can set at all
`define IICB_RAW_IMPL     12'hfeb
`endif

// *** hdl/iicb_clear_bank.v ***
// Overview of operation
// - Reading underflow clear drops status bit 0
// - Reading overflow clear drops status bit 1
// - Reading tx overflow clear drops bit 3
// - Reading read-request clear drops bit 5
// - Abort clear drops bit 6 and abort source
// - Abort clear releases flushed transmit FIFO
// - Abort source bit 9 has clearing exception
// - Reading receive-done clear drops bit 7
// - Activity clear works only when bus idle
// - Activity flag stays set while bus active
// - Hardware drops activity when disabled and idle
// - Activity clear read returns bit 8 state
// - Reading start-detect clear drops bit 10
// - Reading general-call clear drops bit 11
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "iicb_map.vh"

module iicb_clear_bank (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// Interrupt sources, one-cycle pulses
	input  wire        evt_rx_underflow,
	input  wire        evt_rx_overflow,
	input  wire        evt_tx_overflow,
	input  wire        evt_read_request,
	input  wire        evt_tx_abort,
	input  wire        evt_rx_done,
	input  wire        evt_stop_condition,
	input  wire        evt_start_condition,
	input  wire        evt_general_call,
	// Abort cause pulses, one bit per cause
	input  wire [15:0] abort_cause_set,
	// Restart support off keeps abort bit 9
	input  wire        restart_disabled,
	// Controller activity level on the bus
	input  wire        bus_active,
	// Controls and status towards the controller
	output wire        ctrl_enable,
	output wire        tx_fifo_flush_hold,
	output wire        irq
);

	// Access states, one-hot
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_WAIT = 3'h2;
	localparam [2:0] ST_RESP = 3'h4;
	// Idle waits for penable, wait captures the read data,
	// resp raises pready for one cycle; every transfer thus
	// sees two cycles with pready low after its setup cycle
	// Trade: two extra cycles per access for a registered answer

	// Register select indices
	localparam integer SEL_UNDER  = 0;
	localparam integer SEL_OVER   = 1;
	localparam integer SEL_TXOVR  = 2;
	localparam integer SEL_RDREQ  = 3;
	localparam integer SEL_ABORT  = 4;
	localparam integer SEL_DONE   = 5;
	localparam integer SEL_ACT    = 6;
	localparam integer SEL_STOP   = 7;
	localparam integer SEL_START  = 8;
	localparam integer SEL_GCALL  = 9;
	localparam integer SEL_ENA    = 10;
	localparam integer SEL_RAW    = 11;
	localparam integer SEL_MASK   = 12;
	localparam integer SEL_ABSRC  = 13;
	localparam integer SEL_W      = 14;
	// Indices 0 to 9 are read-to-clear registers; their order
	// follows the address map, not the status bit positions

	// Address decode to one-hot select; zero means unmapped
	// Only whole aligned words decode; other byte addresses err
	function [SEL_W-1:0] dec_sel;
		input [31:0] addr;
		begin
			dec_sel = {SEL_W{1'b0}};
			case (addr)
				`IICB_ADDR_RX_UNDERFLOW_CLEAR_FIELD : dec_sel[SEL_UNDER] = 1'b1;
				`IICB_ADDR_RX_OVERFLOW_CLEAR_FIELD  : dec_sel[SEL_OVER]  = 1'b1;
				`IICB_ADDR_TX_OVERFLOW_CLEAR_FIELD  : dec_sel[SEL_TXOVR] = 1'b1;
				`IICB_ADDR_READ_REQUEST_CLEAR_FIELD   : dec_sel[SEL_RDREQ] = 1'b1;
				`IICB_ADDR_CLR_TX_ABORT : dec_sel[SEL_ABORT] = 1'b1;
				`IICB_ADDR_RX_DONE_CLEAR_FIELD  : dec_sel[SEL_DONE]  = 1'b1;
				`IICB_ADDR_BUS_ACTIVITY_CLEAR_FIELD : dec_sel[SEL_ACT]   = 1'b1;
				`IICB_ADDR_CLR_STOP     : dec_sel[SEL_STOP]  = 1'b1;
				`IICB_ADDR_CLR_START    : dec_sel[SEL_START] = 1'b1;
				`IICB_ADDR_GENERAL_CALL_CLEAR_FIELD : dec_sel[SEL_GCALL] = 1'b1;
				`IICB_ADDR_ENABLE       : dec_sel[SEL_ENA]   = 1'b1;
				`IICB_ADDR_RAW_STATUS   : dec_sel[SEL_RAW]   = 1'b1;
				`IICB_ADDR_IRQ_MASK     : dec_sel[SEL_MASK]  = 1'b1;
				`IICB_ADDR_ABORT_SRC    : dec_sel[SEL_ABSRC] = 1'b1;
				default                 : dec_sel = {SEL_W{1'b0}};
			endcase
		end
	endfunction

	// Map a clear register select to its raw status bit
	function [`IICB_RAW_W-1:0] clr_bits;
		input [SEL_W-1:0] sel;
		begin
			clr_bits = {`IICB_RAW_W{1'b0}};
			clr_bits[`IICB_BIT_RX_UNDER] = sel[SEL_UNDER];
			clr_bits[`IICB_BIT_RX_OVER]  = sel[SEL_OVER];
			clr_bits[`IICB_BIT_TX_OVER]  = sel[SEL_TXOVR];
			clr_bits[`IICB_BIT_RD_REQ]   = sel[SEL_RDREQ];
			clr_bits[`IICB_BIT_TX_ABORT] = sel[SEL_ABORT];
			clr_bits[`IICB_BIT_RX_DONE]  = sel[SEL_DONE];
			clr_bits[`IICB_BIT_ACTIVITY] = sel[SEL_ACT];
			clr_bits[`IICB_BIT_STOP]     = sel[SEL_STOP];
			clr_bits[`IICB_BIT_START]    = sel[SEL_START];
			clr_bits[`IICB_BIT_GENERAL_CALL_IRQ] = sel[SEL_GCALL];
		end
	endfunction

	// State and register storage
	reg [2:0]               state_ff;      // Access phase tracker
	reg [2:0]               nxt_state;
	reg [`IICB_RAW_W-1:0]   raw_ff;        // Raw interrupt status
	reg [`IICB_RAW_W-1:0]   nxt_raw;
	reg [`IICB_RAW_W-1:0]   mask_ff;       // Interrupt enable mask
	reg [`IICB_RAW_W-1:0]   nxt_mask;
	reg [`IICB_ABORT_W-1:0] abort_ff;      // Abort source bits
	reg [`IICB_ABORT_W-1:0] nxt_abort;
	reg                     enable_ff;     // Controller enable
	reg                     nxt_enable;
	reg                     flush_ff;      // Transmit FIFO held flushed
	reg                     nxt_flush;
	reg [31:0]              nxt_prdata;
	reg                     nxt_pslverr;

	// Decoded access, set and clear vectors
	wire [SEL_W-1:0]         sel;
	wire                     acc_done;     // Completing edge of a transfer
	wire                     rd_done;
	wire                     wr_done;
	wire [`IICB_RAW_W-1:0]   set_vec;      // Hardware events this cycle
	wire [`IICB_RAW_W-1:0]   rd_clr;       // Read-to-clear requests
	wire [`IICB_RAW_W-1:0]   w1c_clr;      // Software write-one clears
	wire [`IICB_ABORT_W-1:0] abort_keep;   // Bits spared by abort clear
	wire                     act_hw_clr;

	// Decode straight from the address bus, no storage
	assign sel      = dec_sel(paddr);
	// Two wait states: data is captured first, effect lands when ready
	assign pready   = state_ff[2];
	assign acc_done = psel & penable & state_ff[2];
	assign rd_done  = acc_done & ~pwrite;
	assign wr_done  = acc_done & pwrite;

	// Events arrive as single-cycle pulses from the controller;
	// a pulse that lands while its flag is already set is lost,
	// since the flag only records that the event happened
	// Event vector in raw status layout; bits 2 and 4 live elsewhere
	assign set_vec[`IICB_BIT_RX_UNDER] = evt_rx_underflow;
	assign set_vec[`IICB_BIT_RX_OVER]  = evt_rx_overflow;
	assign set_vec[2]                  = 1'b0;
	assign set_vec[`IICB_BIT_TX_OVER]  = evt_tx_overflow;
	assign set_vec[4]                  = 1'b0;
	assign set_vec[`IICB_BIT_RD_REQ]   = evt_read_request;
	assign set_vec[`IICB_BIT_TX_ABORT] = evt_tx_abort;
	assign set_vec[`IICB_BIT_RX_DONE]  = evt_rx_done;
	// Activity is a level: stays set while the bus is busy
	assign set_vec[`IICB_BIT_ACTIVITY] = bus_active;
	assign set_vec[`IICB_BIT_STOP]     = evt_stop_condition;
	assign set_vec[`IICB_BIT_START]    = evt_start_condition;
	assign set_vec[`IICB_BIT_GENERAL_CALL_IRQ] = evt_general_call;

	// Idle gate on the activity clear is belt and braces:
	// a busy bus sets the flag again in the same cycle anyway,
	// so the gate only matters if the set path is ever changed
	// Read clears; activity read clear is gated by an idle bus
	assign rd_clr = clr_bits(rd_done ? sel : {SEL_W{1'b0}})
		& ~({`IICB_RAW_W{1'b0}}
		| ({{(`IICB_RAW_W-1){1'b0}}, bus_active}
		<< `IICB_BIT_ACTIVITY));

	// Write-one-to-clear on the raw status register
	assign w1c_clr = (wr_done & sel[SEL_RAW])
		? pwdata[`IICB_RAW_W-1:0] : {`IICB_RAW_W{1'b0}};

	// Disabled and idle controller drops activity on its own
	assign act_hw_clr = ~enable_ff & ~bus_active;

	// Only the one exception bit is spared; any other abort
	// cause must be read before the clear, or it is gone
	// Bit 9 survives the abort clear while restarts are off
	assign abort_keep = {{(`IICB_ABORT_W-1){1'b0}}, restart_disabled}
		<< `IICB_BIT_ABORT_KEEP;

	// Interrupt is a plain OR of stored bits, so it cannot
	// glitch on bus traffic; it follows a mask write at once
	// Outputs from flip-flops
	assign ctrl_enable        = enable_ff;
	assign tx_fifo_flush_hold = flush_ff;
	assign irq                = |(raw_ff & mask_ff);

	// Access sequencing
	always @* begin
		nxt_state = ST_IDLE;
		case (state_ff)
			ST_IDLE: begin
				// First access cycle: go capture
				if (psel & penable)
					nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				// Capture cycle for read data and error
				nxt_state = ST_RESP;
			end
			ST_RESP: begin
				// Transfer ends here; next setup restarts at idle
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Read data and error captured one cycle before ready
	always @* begin
		nxt_prdata  = prdata;
		nxt_pslverr = pslverr;
		if (state_ff[1]) begin
			nxt_prdata  = 32'h00000000;
			nxt_pslverr = ~(|sel);
			// Flag is read a cycle before the clear lands, so a flag
			// first set in the capture cycle is cleared yet returned as 0
			// Clear registers return the flag they clear
			if (|clr_bits(sel))
				nxt_prdata[0] = |(raw_ff & clr_bits(sel));
			else if (sel[SEL_ENA])
				nxt_prdata[0] = enable_ff;
			else if (sel[SEL_RAW])
				nxt_prdata[`IICB_RAW_W-1:0] = raw_ff;
			else if (sel[SEL_MASK])
				nxt_prdata[`IICB_RAW_W-1:0] = mask_ff;
			else if (sel[SEL_ABSRC])
				nxt_prdata[`IICB_ABORT_W-1:0] = abort_ff;
		end
	end

	// Three clear sources meet here: read-to-clear, write-one
	// clear and the hardware activity clear. A set in the same
	// cycle always wins, yet an event in an earlier cycle of the
	// transfer can still be cleared before software sees the flag
	// Raw status: hardware set wins over any clear in the same cycle
	always @* begin
		nxt_raw = raw_ff & ~rd_clr & ~w1c_clr;
		if (act_hw_clr)
			nxt_raw[`IICB_BIT_ACTIVITY] = 1'b0;
		nxt_raw = (nxt_raw | set_vec) & `IICB_RAW_IMPL;
	end

	// Abort source: cleared by abort read, new causes still land
	always @* begin
		nxt_abort = abort_ff;
		if (rd_done & sel[SEL_ABORT])
			nxt_abort = abort_ff & abort_keep;
		nxt_abort = nxt_abort | abort_cause_set;
	end

	// While held, the transmit buffer is kept empty by the
	// controller; software must read the abort clear to resume
	// Transmit FIFO flush hold: abort engages, abort clear releases
	always @* begin
		nxt_flush = flush_ff;
		if (rd_done & sel[SEL_ABORT])
			nxt_flush = 1'b0;
		// A fresh abort in the same cycle keeps the hold
		if (evt_tx_abort)
			nxt_flush = 1'b1;
	end

	// Mask bits with no status bit behind them stay zero,
	// so a read of the mask shows what can really interrupt
	// Software-writable controls
	always @* begin
		nxt_enable = enable_ff;
		nxt_mask   = mask_ff;
		if (wr_done & sel[SEL_ENA])
			nxt_enable = pwdata[0];
		if (wr_done & sel[SEL_MASK])
			nxt_mask = pwdata[`IICB_RAW_W-1:0] & `IICB_RAW_IMPL;
	end

	// Reset puts the tracker in idle, so a transfer cut by
	// reset simply restarts from its setup cycle
	// State register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Read data holds between transfers; only the capture
	// cycle of the next transfer loads it again
	// Bus response registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= nxt_prdata;
			pslverr <= nxt_pslverr;
		end
	end

	// All state clears together on reset; the flush hold
	// starts released, as no abort can have happened yet,
	// and the controller starts disabled
	// Status and control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_ff    <= `IICB_RAW_RESET;
			mask_ff   <= `IICB_MASK_RESET;
			abort_ff  <= `IICB_ABORT_RESET;
			enable_ff <= `IICB_ENABLE_RESET;
			flush_ff  <= 1'b0;
		end else begin
			raw_ff    <= nxt_raw;
			mask_ff   <= nxt_mask;
			abort_ff  <= nxt_abort;
			enable_ff <= nxt_enable;
			flush_ff  <= nxt_flush;
		end
	end

endmodule // iicb_clear_bank
`default_nettype wire

// *** verif/iicb_clear_bank_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iicb_map.vh"
module iicb_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Controller side
	input wire logic        evt_tx_abort,
	input wire logic        bus_active,
	input wire logic        ctrl_enable,
	input wire logic        tx_fifo_flush_hold
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Address decodes to a real register
	wire mapped = paddr[1:0] == 2'b00 &&
		((paddr >= 32'h50001344 && paddr <= 32'h5000136c) ||
		(paddr >= 32'h50001390 && paddr <= 32'h50001398));
	// Completed read or write at one address
	sequence s_rd(a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence
	sequence s_wr(a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	AST_WAIT: assert property (psel && !penable |=>
		!pready ##1 !pready ##1 pready)
		else $error("wait state count wrong");
	AST_ERR: assert property (pready && pslverr |-> !mapped && prdata == 0)
		else $error("error on mapped address or with data");
	AST_OK: assert property (pready && mapped |-> !pslverr)
		else $error("error flagged on mapped address");
	AST_FLUSH_SET: assert property (evt_tx_abort |=> tx_fifo_flush_hold)
		else $error("abort did not hold transmit buffer");
	AST_FLUSH_CLR: assert property (s_rd(`IICB_ADDR_CLR_TX_ABORT) ##0
		!evt_tx_abort |=> !tx_fifo_flush_hold)
		else $error("abort clear did not release buffer");
	AST_RDATA: assert property (pready && !pwrite && mapped &&
		paddr < 32'h5000136c |-> prdata[31:1] == 31'h0)
		else $error("clear register upper bits not zero");
	AST_ACT: assert property (psel && !penable && !pwrite && bus_active &&
		paddr == `IICB_ADDR_BUS_ACTIVITY_CLEAR_FIELD |-> ##3 (pready && prdata[0]))
		else $error("activity flag lost while bus active");
	AST_EN: assert property (s_wr(`IICB_ADDR_ENABLE) |=>
		ctrl_enable == $past(pwdata[0]))
		else $error("enable bit not written");
endmodule // iicb_chk
bind iicb_clear_bank iicb_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.evt_tx_abort(evt_tx_abort), .bus_active(bus_active),
	.ctrl_enable(ctrl_enable), .tx_fifo_flush_hold(tx_fifo_flush_hold));
`default_nettype wire

// *** verif/iicb_clear_bank_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iicb_map.vh"
module iicb_clear_bank_tb_top;
	logic        pclk = 1'b0;     // Bus clock
	logic        presetn = 1'b0;  // Reset, active low
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [8:0]  ev = 9'h0;       // Event pulses
	logic [15:0] cause = 16'h0;   // Abort cause pulses
	logic        rs_off = 1'b0;   // Restart support off
	logic        act = 1'b0;      // Bus activity level
	logic [31:0] rd;              // Last read data
	logic        er;              // Last error flag
	int          miscompares = 0;
	int          total_checks = 0;
	wire         pready, pslverr, ctrl_enable, hold, irq;
	wire  [31:0] prdata;
	// Clear addresses and their status bits, event order
	logic [31:0] ad [9] = '{32'h50001344, 32'h50001348, 32'h5000134c,
		32'h50001350, 32'h50001354, 32'h50001358, 32'h50001360,
		32'h50001364, 32'h50001368};
	int          bi [9] = '{0, 1, 3, 5, 6, 7, 9, 10, 11};
	iicb_clear_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.evt_rx_underflow(ev[0]), .evt_rx_overflow(ev[1]),
		.evt_tx_overflow(ev[2]), .evt_read_request(ev[3]),
		.evt_tx_abort(ev[4]), .evt_rx_done(ev[5]),
		.evt_stop_condition(ev[6]), .evt_start_condition(ev[7]),
		.evt_general_call(ev[8]), .abort_cause_set(cause),
		.restart_disabled(rs_off), .bus_active(act),
		.ctrl_enable(ctrl_enable), .tx_fifo_flush_hold(hold), .irq(irq));
	always #50 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; idle edge first so no signal is driven twice
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input int i);
		ev <= 9'h1 << i;
		@(posedge pclk);
		ev <= 9'h0;
		@(posedge pclk);
	endtask
	task automatic t_reset;
		apb(1'b0, `IICB_ADDR_RAW_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `IICB_ADDR_ABORT_SRC, 32'h0);
		chk(rd, 32'h0);
		chk({hold, irq, ctrl_enable}, 32'h0);
	endtask
	task automatic t_clears;
		for (int i = 0; i < 9; i++) begin
			pulse(i);
			apb(1'b0, `IICB_ADDR_RAW_STATUS, 32'h0);
			chk(rd, 32'h1 << bi[i]);
			apb(1'b0, ad[i], 32'h0);
			chk(rd, 32'h1);
			apb(1'b0, `IICB_ADDR_RAW_STATUS, 32'h0);
			chk(rd, 32'h0);
		end
	endtask
	task automatic t_abort;
		cause <= 16'h0204;
		ev[4] <= 1'b1;
		rs_off <= 1'b1;
		@(posedge pclk);
		cause <= 16'h0;
		ev <= 9'h0;
		apb(1'b0, `IICB_ADDR_ABORT_SRC, 32'h0);
		chk(rd, 32'h204);
		chk(hold, 1'b1);
		apb(1'b0, `IICB_ADDR_CLR_TX_ABORT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, `IICB_ADDR_ABORT_SRC, 32'h0);
		chk(rd, 32'h200);
		chk(hold, 1'b0);
		rs_off <= 1'b0;
		apb(1'b0, `IICB_ADDR_CLR_TX_ABORT, 32'h0);
		apb(1'b0, `IICB_ADDR_ABORT_SRC, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_act;
		apb(1'b1, `IICB_ADDR_ENABLE, 32'h1);
		apb(1'b0, `IICB_ADDR_ENABLE, 32'h0);
		chk(rd, 32'h1);
		act <= 1'b1;
		apb(1'b0, `IICB_ADDR_BUS_ACTIVITY_CLEAR_FIELD, 32'h0);
		apb(1'b0, `IICB_ADDR_BUS_ACTIVITY_CLEAR_FIELD, 32'h0);
		chk(rd, 32'h1);
		act <= 1'b0;
		apb(1'b0, `IICB_ADDR_BUS_ACTIVITY_CLEAR_FIELD, 32'h0);
		apb(1'b0, `IICB_ADDR_RAW_STATUS, 32'h0);
		chk(rd[8], 1'b0);
		act <= 1'b1;
		apb(1'b1, `IICB_ADDR_ENABLE, 32'h0);
		apb(1'b0, `IICB_ADDR_RAW_STATUS, 32'h0);
		chk(rd[8], 1'b1);
		act <= 1'b0;
		apb(1'b0, `IICB_ADDR_RAW_STATUS, 32'h0);
		chk(rd[8], 1'b0);
	endtask
	task automatic t_irq;
		apb(1'b1, `IICB_ADDR_IRQ_MASK, 32'hfff);
		apb(1'b0, `IICB_ADDR_IRQ_MASK, 32'h0);
		chk(rd, 32'hfeb);
		apb(1'b1, `IICB_ADDR_IRQ_MASK, 32'h1);
		pulse(0);
		chk(irq, 1'b1);
		apb(1'b1, `IICB_ADDR_IRQ_MASK, 32'h0);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, `IICB_ADDR_IRQ_MASK, 32'h1);
		@(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, `IICB_ADDR_RAW_STATUS, 32'h1);
		@(posedge pclk);
		chk(irq, 1'b0);
	endtask
	// Unmapped access errs; writes to a clear register change nothing
	task automatic t_err;
		apb(1'b0, 32'h50001400, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		pulse(1);
		apb(1'b1, `IICB_ADDR_RX_OVERFLOW_CLEAR_FIELD, 32'h1);
		apb(1'b0, `IICB_ADDR_RX_OVERFLOW_CLEAR_FIELD, 32'h0);
		chk(rd, 32'h1);
	endtask
	task automatic give_verdict;
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#500000;
		miscompares++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_clears;
		t_abort;
		t_act;
		t_irq;
		t_err;
		give_verdict;
	end
endmodule // iicb_clear_bank_tb_top
`default_nettype wire
